// file: logic/timer8_pkg.sv
// Purpose: shared constants and types of the 8-bit timer/counter with one compare channel
// Assumes: 32-bit AHB-Lite register bus, word aligned registers, low byte used
// Notes:   offsets are byte addresses inside the block's 256-byte window
package timer8_pkg;

  localparam int          CNT_W       = 8;
  localparam int          PRE_W       = 10;
  localparam logic [7:0]  CNT_BOTTOM  = 8'h00;
  localparam logic [7:0]  CNT_MAX     = 8'hff;

  // register offsets
  localparam logic [7:0]  OFS_CONTROL = 8'h00;
  localparam logic [7:0]  OFS_COUNT   = 8'h04;
  localparam logic [7:0]  OFS_COMPARE = 8'h08;
  localparam logic [7:0]  OFS_MASK    = 8'h0c;
  localparam logic [7:0]  OFS_FLAGS   = 8'h10;

  // control register fields
  localparam int          CS_LSB      = 0;
  localparam int          WGM_LSB     = 3;
  localparam int          COM_LSB     = 5;
  localparam int          FOC_BIT     = 7;

  // mask and flag bits
  localparam int          OVF_IE_BIT  = 0;
  localparam int          CMP_IE_BIT  = 1;
  localparam int          TOV_BIT     = 0;
  localparam int          OCF_BIT     = 1;

  // reset values
  localparam logic [7:0]  CONTROL_RST = 8'h00;
  localparam logic [7:0]  COUNT_RST   = 8'h00;
  localparam logic [7:0]  COMPARE_RST = 8'h00;
  localparam logic [1:0]  MASK_RST    = 2'h0;
  localparam logic [1:0]  FLAGS_RST   = 2'h0;

  // clock source select codes
  localparam logic [2:0]  CS_STOP     = 3'h0;
  localparam logic [2:0]  CS_DIV1     = 3'h1;
  localparam logic [2:0]  CS_DIV8     = 3'h2;
  localparam logic [2:0]  CS_DIV64    = 3'h3;
  localparam logic [2:0]  CS_DIV256   = 3'h4;
  localparam logic [2:0]  CS_DIV1024  = 3'h5;
  localparam logic [2:0]  CS_EXT_FALL = 3'h6;
  localparam logic [2:0]  CS_EXT_RISE = 3'h7;

  // waveform mode codes
  localparam logic [1:0]  WGM_NORMAL  = 2'h0;
  localparam logic [1:0]  WGM_PHASE   = 2'h1;
  localparam logic [1:0]  WGM_CTC     = 2'h2;
  localparam logic [1:0]  WGM_FAST    = 2'h3;

  // compare output action codes
  localparam logic [1:0]  COM_NONE    = 2'h0;
  localparam logic [1:0]  COM_TOGGLE  = 2'h1;
  localparam logic [1:0]  COM_CLEAR   = 2'h2;
  localparam logic [1:0]  COM_SET     = 2'h3;

  typedef enum logic [3:0] {
    MODE_NORMAL = 4'b0001,
    MODE_PHASE  = 4'b0010,
    MODE_CTC    = 4'b0100,
    MODE_FAST   = 4'b1000
  } mode_t;

  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } dir_t;

endpackage

// file: logic/timer8_counter_compare.sv
// Purpose: 8-bit up/down timer/counter with one compare channel, flags and pin override
// Assumes: AHB-Lite single word transfers; global interrupt enable comes from the core
// Notes:   zero wait states; flag bits other than this timer's read as zero
//
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module timer8_counter_compare
  import timer8_pkg::*;
#(
  parameter int PRESCALE_W = PRE_W
) (
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output      logic                    hreadyout,
  output      logic                    hresp,
  output      logic [31:0]             hrdata,
  input  wire logic                    ext_tick_pin,
  input  wire logic                    global_int_enable,
  input  wire logic                    overflow_vector_ack,
  input  wire logic                    compare_vector_ack,
  input  wire logic                    port_output_value,
  input  wire logic                    compare_pin_direction_bit,
  output      logic                    compare_output_pin_o,
  output      logic                    compare_output_pin_oe,
  output      logic                    overflow_irq,
  output      logic                    compare_irq,
  output      logic                    at_bottom,
  output      logic                    at_max,
  output      logic                    at_top
);
  import timer8_pkg::*;

  if (PRESCALE_W < 10) begin : g_check
    $error("PRESCALE_W must be at least 10 to serve the 1024 divider");
  end

  function automatic mode_t decode_mode(input logic [1:0] wgm);
    mode_t m;
    m = MODE_NORMAL;
    unique case (wgm)
      WGM_PHASE: m = MODE_PHASE;
      WGM_CTC:   m = MODE_CTC;
      WGM_FAST:  m = MODE_FAST;
      default:   m = MODE_NORMAL;
    endcase
    return m;
  endfunction

  // non-PWM compare action; the current level is kept for no action
  function automatic logic apply_action(input logic [1:0] com, input logic cur);
    logic r;
    r = cur;
    unique case (com)
      COM_TOGGLE: r = ~cur;
      COM_CLEAR:  r = 1'b0;
      COM_SET:    r = 1'b1;
      default:    r = cur;
    endcase
    return r;
  endfunction

  // bus state
  logic       dph_wr_q, dph_wr_d;
  logic [7:0] dph_addr_q, dph_addr_d;
  logic [31:0] hrdata_q, hrdata_d;

  // register state
  logic [7:0] control_q, control_d;
  logic [7:0] count_q, count_d;
  logic [7:0] compare_q, compare_d;
  logic [7:0] compare_act_q, compare_act_d;
  logic [1:0] mask_q, mask_d;
  logic [1:0] flags_q, flags_d;
  logic       oc_q, oc_d;
  dir_t       dir_q, dir_d;
  logic       bottom_q, bottom_d;
  logic       max_q, max_d;
  logic       top_q, top_d;

  // tick generation
  logic [PRESCALE_W-1:0] pre_q, pre_d;
  logic       ext_s1_q, ext_s2_q, ext_s3_q;
  logic       tick;

  // decoded controls
  logic [2:0] cs;
  logic [1:0] com;
  mode_t      mode;
  logic       wr_control, wr_count, wr_compare, wr_mask, wr_flags;
  logic       addr_phase;
  logic       match, ovf, force_now;
  logic [7:0] top_val;
  logic [7:0] wdata;

  assign cs    = control_q[CS_LSB +: 3];
  assign com   = control_q[COM_LSB +: 2];
  assign mode  = decode_mode(control_q[WGM_LSB +: 2]);
  assign wdata = hwdata[7:0];

  // ---------------- bus slave ----------------
  assign addr_phase = hsel & hready & htrans[1];
  assign wr_control = dph_wr_q & (dph_addr_q == OFS_CONTROL);
  assign wr_count   = dph_wr_q & (dph_addr_q == OFS_COUNT);
  assign wr_compare = dph_wr_q & (dph_addr_q == OFS_COMPARE);
  assign wr_mask    = dph_wr_q & (dph_addr_q == OFS_MASK);
  assign wr_flags   = dph_wr_q & (dph_addr_q == OFS_FLAGS);

  // read data is taken from next values so a read right after a write sees it
  always_comb begin
    dph_wr_d   = addr_phase & hwrite;
    dph_addr_d = addr_phase ? haddr[7:0] : dph_addr_q;
    hrdata_d   = hrdata_q;
    if (addr_phase && !hwrite) begin
      unique case (haddr[7:0])
        OFS_CONTROL: hrdata_d = {24'h000000, 1'b0, control_d[6:0]};
        OFS_COUNT:   hrdata_d = {24'h000000, count_d};
        OFS_COMPARE: hrdata_d = {24'h000000, compare_d};
        OFS_MASK:    hrdata_d = {30'h0, mask_d};
        OFS_FLAGS:   hrdata_d = {30'h0, flags_d};
        default:     hrdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dph_wr_q   <= 1'b0;
      dph_addr_q <= 8'h00;
      hrdata_q   <= 32'h00000000;
    end else begin
      dph_wr_q   <= dph_wr_d;
      dph_addr_q <= dph_addr_d;
      hrdata_q   <= hrdata_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // ---------------- tick source ----------------
  // external pin passes three flops; the edge is seen between second and third
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_tick_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // free running prescaler; phase is not reset on a source change
  assign pre_d = pre_q + {{(PRESCALE_W-1){1'b0}}, 1'b1};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_d;
    end
  end

  always_comb begin
    unique case (cs)
      CS_DIV1:     tick = 1'b1;
      CS_DIV8:     tick = &pre_q[2:0];
      CS_DIV64:    tick = &pre_q[5:0];
      CS_DIV256:   tick = &pre_q[7:0];
      CS_DIV1024:  tick = &pre_q[9:0];
      CS_EXT_FALL: tick = ext_s3_q & ~ext_s2_q;
      CS_EXT_RISE: tick = ext_s2_q & ~ext_s3_q;
      default:     tick = 1'b0;
    endcase
  end

  // ---------------- counter unit and waveform ----------------
  // top follows the next active compare so at_top lines up with the count
  assign top_val   = ((mode == MODE_CTC) ? compare_act_d : CNT_MAX);
  assign match     = tick & (count_q == compare_act_q);
  assign force_now = wr_control & wdata[FOC_BIT] &
                     ((decode_mode(wdata[WGM_LSB +: 2]) == MODE_NORMAL) ||
                      (decode_mode(wdata[WGM_LSB +: 2]) == MODE_CTC));

  always_comb begin
    count_d       = count_q;
    dir_d         = dir_q;
    oc_d          = oc_q;
    ovf           = 1'b0;
    compare_act_d = compare_act_q;
    if (tick) begin
      unique case (mode)
        MODE_NORMAL: begin
          count_d = count_q + 8'h01;
          ovf     = (count_q == CNT_MAX);
          dir_d   = DIR_UP;
          if (match) begin
            oc_d = apply_action(com, oc_q);
          end
        end
        MODE_CTC: begin
          if (count_q == compare_act_q) begin
            count_d = CNT_BOTTOM;
          end else begin
            count_d = count_q + 8'h01;
          end
          ovf   = (count_q == CNT_MAX);
          dir_d = DIR_UP;
          if (match) begin
            oc_d = apply_action(com, oc_q);
          end
        end
        MODE_FAST: begin
          count_d = count_q + 8'h01;
          ovf     = (count_q == CNT_MAX);
          dir_d   = DIR_UP;
          if (match && com == COM_CLEAR) begin
            oc_d = 1'b0;
          end else if (match && com == COM_SET) begin
            oc_d = 1'b1;
          end else if (count_q == CNT_MAX && com == COM_CLEAR) begin
            oc_d = 1'b1;
          end else if (count_q == CNT_MAX && com == COM_SET) begin
            oc_d = 1'b0;
          end
          if (count_q == CNT_MAX) begin
            compare_act_d = compare_q;
          end
        end
        MODE_PHASE: begin
          if (dir_q == DIR_UP) begin
            if (count_q == CNT_MAX) begin
              dir_d         = DIR_DOWN;
              count_d       = count_q - 8'h01;
              compare_act_d = compare_q;
            end else begin
              count_d = count_q + 8'h01;
            end
          end else begin
            if (count_q == CNT_BOTTOM) begin
              dir_d   = DIR_UP;
              count_d = count_q + 8'h01;
              ovf     = 1'b1;
            end else begin
              count_d = count_q - 8'h01;
            end
          end
          if (match && com == COM_CLEAR) begin
            oc_d = (dir_q == DIR_DOWN);
          end else if (match && com == COM_SET) begin
            oc_d = (dir_q == DIR_UP);
          end
        end
        default: begin
          count_d = count_q;
        end
      endcase
    end
    if (mode == MODE_NORMAL || mode == MODE_CTC) begin
      compare_act_d = compare_q;
    end
    // software write to the count wins over a tick in the same cycle
    if (wr_count) begin
      count_d = wdata;
    end
    // force uses the action being written and sets no flag
    if (force_now) begin
      oc_d = apply_action(wdata[COM_LSB +: 2], oc_q);
    end
  end

  // boundary indications follow the count one cycle behind its next value
  always_comb begin
    bottom_d = (count_d == CNT_BOTTOM);
    max_d    = (count_d == CNT_MAX);
    top_d    = (count_d == top_val);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_q       <= COUNT_RST;
      dir_q         <= DIR_UP;
      oc_q          <= 1'b0;
      compare_act_q <= COMPARE_RST;
      bottom_q      <= 1'b1;
      max_q         <= 1'b0;
      top_q         <= 1'b0;
    end else begin
      count_q       <= count_d;
      dir_q         <= dir_d;
      oc_q          <= oc_d;
      compare_act_q <= compare_act_d;
      bottom_q      <= bottom_d;
      max_q         <= max_d;
      top_q         <= top_d;
    end
  end

  assign at_bottom = bottom_q;
  assign at_max    = max_q;
  assign at_top    = top_q;

  // ---------------- software registers ----------------
  // the force bit is a strobe and is never stored
  always_comb begin
    control_d = control_q;
    compare_d = compare_q;
    mask_d    = mask_q;
    if (wr_control) begin
      control_d = {1'b0, wdata[6:0]};
    end
    if (wr_compare) begin
      compare_d = wdata;
    end
    if (wr_mask) begin
      mask_d = wdata[1:0];
    end
  end

  // a hardware set wins over a clear in the same cycle
  always_comb begin
    flags_d[OCF_BIT] = match |
      (flags_q[OCF_BIT] & ~((wr_flags & wdata[OCF_BIT]) | compare_vector_ack));
    flags_d[TOV_BIT] = ovf |
      (flags_q[TOV_BIT] & ~((wr_flags & wdata[TOV_BIT]) | overflow_vector_ack));
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      control_q <= CONTROL_RST;
      compare_q <= COMPARE_RST;
      mask_q    <= MASK_RST;
      flags_q   <= FLAGS_RST;
    end else begin
      control_q <= control_d;
      compare_q <= compare_d;
      mask_q    <= mask_d;
      flags_q   <= flags_d;
    end
  end

  // ---------------- requests and pin ----------------
  assign compare_irq  = global_int_enable & mask_q[CMP_IE_BIT] & flags_q[OCF_BIT];
  assign overflow_irq = global_int_enable & mask_q[OVF_IE_BIT] & flags_q[TOV_BIT];

  // override ignores the waveform mode; the direction bit alone drives the enable
  assign compare_output_pin_o  = (com != COM_NONE) ? oc_q : port_output_value;
  assign compare_output_pin_oe = compare_pin_direction_bit;

endmodule // timer8_counter_compare

// file: verif/timer8_properties.sv
// Purpose: port-level properties of the 8-bit timer with one compare channel
// Assumes: one clock, asynchronous active-low reset
// Notes:   register state is not visible here, so only relations between ports are checked
`timescale 1ns/10ps
module timer8_properties (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic global_int_enable,
  input wire logic overflow_vector_ack,
  input wire logic compare_pin_direction_bit,
  input wire logic compare_output_pin_oe,
  input wire logic overflow_irq,
  input wire logic compare_irq,
  input wire logic at_bottom,
  input wire logic at_max
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_ovf_irq_gate: assert property (overflow_irq |-> global_int_enable)
    else $error("overflow request without global enable");
  chk_cmp_irq_gate: assert property (compare_irq |-> global_int_enable)
    else $error("compare request without global enable");
  chk_irq_gie_off: assert property ($fell(global_int_enable) |-> !overflow_irq && !compare_irq)
    else $error("request outlived global enable");
  chk_oe_follows_dir: assert property (compare_output_pin_oe == compare_pin_direction_bit)
    else $error("pin enable differs from direction bit");
  chk_bound_excl: assert property (!(at_bottom && at_max))
    else $error("bottom and max at once");
  // a wrap in the ack cycle may set the flag again, so those cycles are skipped
  chk_ovf_ack_clr: assert property (overflow_irq && overflow_vector_ack && !at_bottom && !at_max
    |=> !overflow_irq) else $error("vector ack left overflow set");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  chk_reset_bottom: assert property ($rose(rstn) |-> at_bottom)
    else $error("bottom not shown after reset");
endmodule // timer8_properties

// file: verif/timer8_counter_compare_test.sv
// Purpose: self-checking bench of the timer over its AHB-Lite registers and pins
// Assumes: zero wait-state slave, default prescaler width
// Notes:   prescaler counts are checked to one tick, as the free prescaler phase is unknown
`timescale 1ns/10ps
module timer8_counter_compare_test;
  import timer8_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        ext_tick_pin = 1'b0;
  logic        global_int_enable = 1'b0;
  logic        overflow_vector_ack = 1'b0;
  logic        compare_vector_ack = 1'b0;
  logic        port_output_value = 1'b0;
  logic        compare_pin_direction_bit = 1'b1;
  logic        hreadyout, hresp, pin_o, pin_oe, overflow_irq, compare_irq, at_bottom, at_max, at_top;
  logic [31:0] hrdata, rv;
  int          n_fail = 0;
  int          total_checks = 0;

  always #25 clk = ~clk;

  timer8_counter_compare DUT (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .ext_tick_pin, .global_int_enable,
    .overflow_vector_ack, .compare_vector_ack, .port_output_value, .compare_pin_direction_bit,
    .compare_output_pin_o(pin_o), .compare_output_pin_oe(pin_oe), .overflow_irq, .compare_irq,
    .at_bottom, .at_max, .at_top);

  task automatic finish_test();
    if (n_fail == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_ready();
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      finish_test();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, a, {24'h0, d}, x);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, rv);
    chk(rv, e);
  endtask

  // sampled mid-cycle so the edge's updates have landed
  task automatic pin(input logic e);
    @(negedge clk);
    chk({31'h0, pin_o}, {31'h0, e});
  endtask

  task automatic wait_ovf(input int lim, output int n);
    n = 0;
    while (overflow_irq !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (n >= lim) begin
      n_fail++;
      finish_test();
    end
  endtask

  function automatic logic [7:0] ctl(input logic [2:0] cs, input logic [1:0] m, input logic [1:0] a,
                                     input logic f);
    return {f, a, m, cs};
  endfunction

  initial begin
    int n;
    int ex [8] = '{0, 0, 65, 8, 2, 0, 4, 4};
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    chk({31'h0, at_bottom}, 32'h1);
    rdc(OFS_FLAGS, 32'h0);
    rdc(OFS_CONTROL, 32'h0);
    wr(OFS_COUNT, 8'hff);
    @(negedge clk);
    chk({31'h0, at_max}, 32'h1);
    chk({31'h0, at_top}, 32'h1);
    wr(OFS_COUNT, 8'h55);
    repeat (20) @(posedge clk);
    rdc(OFS_COUNT, 32'h55);
    rdc(8'h40, 32'h0);
    wr(OFS_CONTROL, ctl(CS_STOP, WGM_NORMAL, COM_SET, 1'b1));
    pin(1'b1);
    wr(OFS_CONTROL, ctl(CS_STOP, WGM_NORMAL, COM_CLEAR, 1'b1));
    pin(1'b0);
    wr(OFS_CONTROL, ctl(CS_STOP, WGM_CTC, COM_TOGGLE, 1'b1));
    pin(1'b1);
    wr(OFS_CONTROL, ctl(CS_STOP, WGM_NORMAL, COM_NONE, 1'b1));
    pin(1'b0);
    wr(OFS_CONTROL, ctl(CS_STOP, WGM_NORMAL, COM_CLEAR, 1'b0));
    pin(1'b1);
    @(posedge clk);
    compare_pin_direction_bit <= 1'b0;
    wr(OFS_CONTROL, ctl(CS_STOP, WGM_NORMAL, COM_CLEAR, 1'b1));
    pin(1'b0);
    chk({31'h0, pin_oe}, 32'h0);
    @(posedge clk);
    compare_pin_direction_bit <= 1'b1;
    wr(OFS_COMPARE, 8'h05);
    wr(OFS_COUNT, 8'h00);
    wr(OFS_CONTROL, ctl(CS_DIV1, WGM_NORMAL, COM_SET, 1'b0));
    pin(1'b0);
    repeat (10) @(posedge clk);
    pin(1'b1);
    rdc(OFS_FLAGS, 32'h2);
    wr(OFS_FLAGS, 8'h02);
    rdc(OFS_FLAGS, 32'h0);
    @(posedge clk);
    global_int_enable <= 1'b1;
    wr(OFS_MASK, 8'h03);
    wait_ovf(300, n);
    bus(1'b0, OFS_FLAGS, 32'h0, rv);
    chk(rv & 32'h1, 32'h1);
    repeat (10) @(posedge clk);
    chk({31'h0, compare_irq}, 32'h1);
    overflow_vector_ack <= 1'b1;
    @(posedge clk);
    overflow_vector_ack <= 1'b0;
    @(negedge clk);
    chk({31'h0, overflow_irq}, 32'h0);
    @(posedge clk);
    global_int_enable <= 1'b0;
    @(negedge clk);
    chk({31'h0, compare_irq}, 32'h0);
    wr(OFS_MASK, 8'h01);
    global_int_enable <= 1'b1;
    @(negedge clk);
    chk({31'h0, compare_irq}, 32'h0);
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_FLAGS, 8'h03);
    wr(OFS_COUNT, 8'h03);
    wr(OFS_CONTROL, ctl(CS_DIV1, WGM_PHASE, COM_NONE, 1'b0));
    wait_ovf(1000, n);
    chk({31'h0, n > 400}, 32'h1);
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_FLAGS, 8'h03);
    wr(OFS_COMPARE, 8'h10);
    wr(OFS_CONTROL, ctl(CS_STOP, WGM_CTC, COM_NONE, 1'b0));
    wr(OFS_COUNT, 8'h10);
    @(negedge clk);
    chk({31'h0, at_top}, 32'h1);
    chk({31'h0, at_max}, 32'h0);
    wr(OFS_COUNT, 8'h00);
    wr(OFS_CONTROL, ctl(CS_DIV1, WGM_CTC, COM_NONE, 1'b0));
    repeat (300) @(posedge clk);
    chk({31'h0, overflow_irq}, 32'h0);
    bus(1'b0, OFS_COUNT, 32'h0, rv);
    chk({31'h0, rv <= 32'h10}, 32'h1);
    // fast pwm, clear action: low after the match at 0x10, high again after the wrap
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_COUNT, 8'h00);
    wr(OFS_CONTROL, ctl(CS_DIV1, WGM_FAST, COM_CLEAR, 1'b0));
    repeat (40) @(posedge clk);
    pin(1'b0);
    repeat (225) @(posedge clk);
    pin(1'b1);
    // prescaled and external sources; external edges are counted exactly
    for (int cs = 2; cs <= 7; cs++) begin
      wr(OFS_CONTROL, 8'h00);
      wr(OFS_COUNT, 8'h00);
      wr(OFS_CONTROL, ctl(3'(cs), WGM_NORMAL, COM_NONE, 1'b0));
      for (int k = 0; k < 8; k++) begin
        repeat (64) @(posedge clk);
        ext_tick_pin <= ~ext_tick_pin;
      end
      repeat (8) @(posedge clk);
      wr(OFS_CONTROL, 8'h00);
      bus(1'b0, OFS_COUNT, 32'h0, rv);
      if (cs < 6)
        chk({31'h0, rv + 1 >= ex[cs] && rv <= ex[cs] + 1}, 32'h1);
      else
        chk(rv, 32'h4);
    end
    finish_test();
  end
endmodule // timer8_counter_compare_test

bind timer8_counter_compare timer8_properties u_props (.clk, .rstn, .hreadyout, .hresp, .global_int_enable,
  .overflow_vector_ack, .compare_pin_direction_bit, .compare_output_pin_oe, .overflow_irq, .compare_irq,
  .at_bottom, .at_max);
